// ---- pkg/sensor_cfg_defs.svh ----
// constants for the sensor configuration command unit
`ifndef SENSOR_CFG_DEFS_SVH
`define SENSOR_CFG_DEFS_SVH
// command codes
`define CMD_ENTER_COMMAND 16'h7274
`define CMD_EEP_TO_RAM 16'h00C0
`define CMD_START_CYCLE 16'h0002
`define CMD_RAM_TO_EEP 16'h00C3
// memory geometry
`define MEM_WORDS 32
`define MEM_AW 5
`define MEM_DW 16
`define MEM_LAST 5'h1F
// free user words
`define FREE_USER_WORD_A 5'h1C
`define FREE_USER_WORD_B 5'h1D
`define FREE_USER_WORD_C 5'h1E
// front end word and fields
`define CFG_AFE_ADDR 5'h19
`define AFE_POL_BIT 0
`define AFE_CAL_TS_LSB 1
`define AFE_AMB_TS_LSB 4
`define AFE_RES_LSB 8
// protection word and fields
`define CFG_PROT_ADDR 5'h1A
`define PROT_BROKEN_BIT 0
`define PROT_SHORT_BIT 1
`define PROT_CONNHC_BIT 2
`define PROT_CONN_BIT 3
`define PROT_AGING_BIT 4
`define PROT_LOCK_BIT 5
`define PROT_ROMCHK_BIT 6
`define PROT_ROMDIAG_BIT 7
`define PROT_DIAG_MODE_SELF_RESET_EN_BIT 8
`define PROT_BOOST_BIT 9
// timing
`define CLK_MHZ 250
`define ROM_CHECK_TIME_US 10000
`define ROM_CHECK_CYCLES (`ROM_CHECK_TIME_US * `CLK_MHZ)
`endif

// ---- pkg/sensor_cfg_pkg.sv ----
// types for the sensor configuration command unit
`default_nettype none
package sensor_cfg_pkg;
   typedef enum logic [2:0] {
      ST_BOOT_COPY = 3'b000,
      ST_ROM_CHECK = 3'b001,
      ST_NORMAL = 3'b010,
      ST_COMMAND = 3'b011,
      ST_COPY_E2R = 3'b100,
      ST_COPY_R2E = 3'b101,
      ST_DIAG = 3'b110
   } unit_state_e;
endpackage
`default_nettype wire

// ---- hw/sensor_config_command_unit.sv ----
// command handling and protection options of the sensor conditioner
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_defs.svh"
module sensor_config_command_unit #(
   parameter int ROM_CHECK_CYCLES = `ROM_CHECK_CYCLES,
   parameter int ADC_W = 24
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic i_CMD_VALID,
   input wire logic [15:0] i_CMD_CODE,
   input wire logic i_CMD_FROM_LIN,
   input wire logic i_WR_VALID,
   input wire logic [4:0] i_WR_ADDR,
   input wire logic [15:0] i_WR_DATA,
   input wire logic [4:0] i_RD_ADDR,
   input wire logic i_ROM_FAIL,
   input wire logic i_CYCLE_START,
   input wire logic signed [ADC_W-1:0] i_ADC_RAW,
   output logic [15:0] o_RD_DATA,
   output logic [2:0] o_MODE,
   output logic o_CMD_MODE,
   output logic o_MEASURE_RUN,
   output logic o_BUSY,
   output logic o_CMD_REFUSED,
   output logic o_SELF_RESET,
   output logic [4:0] o_CHECK_EN,
   output logic o_BIAS_BOOST,
   output logic [2:0] o_CAL_TS,
   output logic [2:0] o_AMB_TS,
   output logic [ADC_W:0] o_ADC_CODE
);
   sensor_cfg_pkg::unit_state_e state_reg, state_next;
   logic [15:0] ram [0:`MEM_WORDS-1];
   logic [15:0] eep [0:`MEM_WORDS-1];
   logic [4:0] idx_reg;
   logic [31:0] rom_cnt_reg;
   logic boot_reg;
   logic [15:0] prot, afe;
   logic cmd_ok, lin_locked, ram_wr_ok;
   logic [4:0] res;
   logic signed [ADC_W:0] adc_pol;

   // assertions below share the one clock and reset
   default clocking cb_main @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);

   // reads a one-bit field of a configuration word
   function automatic logic field(input logic [15:0] w, input int b);
      return w[b];
   endfunction

   assign prot = ram[`CFG_PROT_ADDR];
   assign afe = ram[`CFG_AFE_ADDR];
   assign cmd_ok = i_CMD_VALID && state_reg == sensor_cfg_pkg::ST_COMMAND;
   // lin writes to nonvolatile memory blocked by lock
   assign lin_locked = i_CMD_FROM_LIN && field(prot, `PROT_LOCK_BIT);
   assign ram_wr_ok = i_WR_VALID && state_reg == sensor_cfg_pkg::ST_COMMAND
                    && !(cmd_ok && i_CMD_CODE == `CMD_EEP_TO_RAM);
   assign res = afe[`AFE_RES_LSB +: 5];

   // next state: commands come from either interface alike, except a ram to eeprom copy from lin while locked
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         sensor_cfg_pkg::ST_BOOT_COPY: begin
            if (idx_reg == `MEM_LAST) begin
               if (field(eep[`CFG_PROT_ADDR], `PROT_ROMCHK_BIT) ||
                   field(eep[`CFG_PROT_ADDR], `PROT_ROMDIAG_BIT)) begin
                  state_next = sensor_cfg_pkg::ST_ROM_CHECK;
               end else begin
                  state_next = sensor_cfg_pkg::ST_NORMAL;
               end
            end
         end
         sensor_cfg_pkg::ST_ROM_CHECK: begin
            if (rom_cnt_reg >= 32'(ROM_CHECK_CYCLES - 1)) begin
               state_next = i_ROM_FAIL ? sensor_cfg_pkg::ST_DIAG
                                       : sensor_cfg_pkg::ST_NORMAL;
            end
         end
         sensor_cfg_pkg::ST_NORMAL, sensor_cfg_pkg::ST_DIAG: begin
            if (state_reg == sensor_cfg_pkg::ST_DIAG &&
                field(prot, `PROT_DIAG_MODE_SELF_RESET_EN_BIT)) begin
               state_next = sensor_cfg_pkg::ST_BOOT_COPY;
            end else if (i_CMD_VALID &&
                         i_CMD_CODE == `CMD_ENTER_COMMAND) begin
               state_next = sensor_cfg_pkg::ST_COMMAND;
            end
         end
         sensor_cfg_pkg::ST_COMMAND: begin
            if (i_CMD_VALID) begin
               if (i_CMD_CODE == `CMD_EEP_TO_RAM) begin
                  state_next = sensor_cfg_pkg::ST_COPY_E2R;
               end else if (i_CMD_CODE == `CMD_START_CYCLE) begin
                  state_next = sensor_cfg_pkg::ST_NORMAL;
               end else if (i_CMD_CODE == `CMD_RAM_TO_EEP &&
                            !lin_locked) begin
                  state_next = sensor_cfg_pkg::ST_COPY_R2E;
               end
            end
         end
         sensor_cfg_pkg::ST_COPY_E2R, sensor_cfg_pkg::ST_COPY_R2E: begin
            if (idx_reg == `MEM_LAST) begin
               state_next = sensor_cfg_pkg::ST_COMMAND;
            end
         end
         default: begin
            state_next = sensor_cfg_pkg::ST_BOOT_COPY;
         end
      endcase
   end

   // state register
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_reg <= sensor_cfg_pkg::ST_BOOT_COPY;
      end else begin
         state_reg <= state_next;
      end
   end

   // word index for the copy loops, restarts on each copy
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         idx_reg <= 5'h00;
      end else if (state_reg != state_next) begin
         idx_reg <= 5'h00;
      end else if (state_reg == sensor_cfg_pkg::ST_BOOT_COPY ||
                   state_reg == sensor_cfg_pkg::ST_COPY_E2R ||
                   state_reg == sensor_cfg_pkg::ST_COPY_R2E) begin
         idx_reg <= idx_reg + 5'h01;
      end
   end

   // rom check duration counter
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rom_cnt_reg <= 32'h0000_0000;
      end else if (state_reg == sensor_cfg_pkg::ST_ROM_CHECK) begin
         rom_cnt_reg <= rom_cnt_reg + 32'h0000_0001;
      end else begin
         rom_cnt_reg <= 32'h0000_0000;
      end
   end

   // working ram: whole image from eeprom, or software writes
   always_ff @(posedge I_CLK) begin
      if (state_reg == sensor_cfg_pkg::ST_BOOT_COPY ||
          state_reg == sensor_cfg_pkg::ST_COPY_E2R) begin
         ram[idx_reg] <= eep[idx_reg];
      end else if (ram_wr_ok) begin
         ram[i_WR_ADDR] <= i_WR_DATA;
      end
   end

   // nonvolatile image: every word, free user words included
   always_ff @(posedge I_CLK) begin
      if (state_reg == sensor_cfg_pkg::ST_COPY_R2E) begin
         eep[idx_reg] <= ram[idx_reg];
      end
   end

   // read port and mode outputs
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_RD_DATA <= 16'h0000;
         o_MODE <= 3'h0;
         o_CMD_MODE <= 1'b0;
         o_MEASURE_RUN <= 1'b0;
         o_BUSY <= 1'b1;
      end else begin
         o_RD_DATA <= ram[i_RD_ADDR];
         o_MODE <= state_next;
         o_CMD_MODE <= state_next == sensor_cfg_pkg::ST_COMMAND;
         o_MEASURE_RUN <= state_next == sensor_cfg_pkg::ST_NORMAL;
         o_BUSY <= state_next == sensor_cfg_pkg::ST_BOOT_COPY ||
                   state_next == sensor_cfg_pkg::ST_ROM_CHECK ||
                   state_next == sensor_cfg_pkg::ST_COPY_E2R ||
                   state_next == sensor_cfg_pkg::ST_COPY_R2E;
      end
   end

   // refusal and self reset pulses
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_CMD_REFUSED <= 1'b0;
         o_SELF_RESET <= 1'b0;
      end else begin
         o_CMD_REFUSED <= cmd_ok && i_CMD_CODE == `CMD_RAM_TO_EEP
                          && lin_locked;
         o_SELF_RESET <= state_reg == sensor_cfg_pkg::ST_DIAG &&
                         field(prot, `PROT_DIAG_MODE_SELF_RESET_EN_BIT);
      end
   end

   // check enables and front end settings taken at cycle start
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_CHECK_EN <= 5'h00;
         o_BIAS_BOOST <= 1'b0;
         o_CAL_TS <= 3'h0;
         o_AMB_TS <= 3'h0;
      end else if (state_next == sensor_cfg_pkg::ST_NORMAL &&
                   (i_CYCLE_START ||
                    state_reg != sensor_cfg_pkg::ST_NORMAL)) begin
         o_CHECK_EN <= prot[`PROT_AGING_BIT:`PROT_BROKEN_BIT];
         o_BIAS_BOOST <= field(prot, `PROT_BOOST_BIT);
         o_CAL_TS <= afe[`AFE_CAL_TS_LSB +: 3];
         o_AMB_TS <= afe[`AFE_AMB_TS_LSB +: 3];
      end
   end

   // polarity inversion then saturation of the converter result
   assign adc_pol = field(afe, `AFE_POL_BIT) ? -(ADC_W+1)'(i_ADC_RAW)
                                             : (ADC_W+1)'(i_ADC_RAW);
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_ADC_CODE <= '0;
      end else if (adc_pol < 0) begin
         o_ADC_CODE <= '0;
      end else if (adc_pol >= ((ADC_W+1)'(1) << res)) begin
         o_ADC_CODE <= (ADC_W+1)'(1) << res;
      end else begin
         o_ADC_CODE <= adc_pol;
      end
   end

   // checks
   sequence s_copy_walk;
      (state_reg == sensor_cfg_pkg::ST_COPY_E2R) ##32
      (state_reg == sensor_cfg_pkg::ST_COMMAND);
   endsequence
   chk_eep_ram_copy: assert property (
      cmd_ok && i_CMD_CODE == `CMD_EEP_TO_RAM |=> s_copy_walk)
      else $error("eep to ram copy length wrong");
   chk_start_cycle: assert property (
      cmd_ok && i_CMD_CODE == `CMD_START_CYCLE |=>
      o_MEASURE_RUN && !o_CMD_MODE)
      else $error("start cycle did not run");
   chk_ram_eep_copy: assert property (
      cmd_ok && i_CMD_CODE == `CMD_RAM_TO_EEP && !lin_locked |=>
      o_BUSY [*8])
      else $error("ram to eep copy not busy");
   chk_lin_lock: assert property (
      cmd_ok && i_CMD_CODE == `CMD_RAM_TO_EEP && lin_locked |=>
      o_CMD_REFUSED && o_CMD_MODE)
      else $error("locked lin write not refused");
   // skipped while the front end word has never been written
   chk_adc_range: assert property (
      res <= 5'(ADC_W) |=> o_ADC_CODE <= ((ADC_W+1)'(1) << $past(res)))
      else $error("adc code above full scale");
   chk_rom_diag: assert property (
      state_reg == sensor_cfg_pkg::ST_ROM_CHECK && i_ROM_FAIL &&
      rom_cnt_reg == 32'(ROM_CHECK_CYCLES - 1) |=>
      state_reg == sensor_cfg_pkg::ST_DIAG)
      else $error("rom error did not reach diag");
   chk_diag_reset: assert property (
      state_reg == sensor_cfg_pkg::ST_DIAG && field(prot, `PROT_DIAG_MODE_SELF_RESET_EN_BIT)
      |=> o_SELF_RESET && state_reg == sensor_cfg_pkg::ST_BOOT_COPY)
      else $error("diag self reset missing");
   // a command may follow at once, so only the first cycle is checked
   chk_enter_cmd: assert property (
      state_reg == sensor_cfg_pkg::ST_NORMAL && i_CMD_VALID &&
      i_CMD_CODE == `CMD_ENTER_COMMAND |=>
      o_CMD_MODE && o_MODE == 3'(sensor_cfg_pkg::ST_COMMAND))
      else $error("command mode not entered");
   chk_enable_hold: assert property (
      state_reg == sensor_cfg_pkg::ST_NORMAL && !i_CYCLE_START &&
      state_next == sensor_cfg_pkg::ST_NORMAL |=> $stable(o_CHECK_EN))
      else $error("check enables changed mid cycle");
endmodule
`default_nettype wire

// ---- tb/host_master_model.sv ----
// external master model issuing commands and ram word writes
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [15:0] cmd_code,
   output logic cmd_from_lin,
   output logic wr_valid,
   output logic [4:0] wr_addr,
   output logic [15:0] wr_data
);
   // idle bus with strobes low
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 16'h0000;
      cmd_from_lin = 1'b0;
      wr_valid = 1'b0;
      wr_addr = 5'h00;
      wr_data = 16'h0000;
   end
   // one code per strobe, held over exactly one sampling edge
   task automatic send_cmd(input logic [15:0] code, input logic lin);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_from_lin = lin;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~code; // stale code never repeats a command
   endtask
   // one ram word write
   task automatic write_word(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      wr_valid = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(posedge clk);
      #1;
      wr_valid = 1'b0;
      wr_data = ~d;
   endtask
endmodule
`default_nettype wire

// ---- tb/sensor_config_command_unit_bench.sv ----
// self-checking bench of the sensor configuration command unit
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_defs.svh"
module sensor_config_command_unit_bench;
   localparam int ROM_CYC = 16;
   logic clk, rstn, rom_fail, cyc_start, cmd_valid, cmd_lin, wr_valid;
   logic [15:0] cmd_code, wr_data, rd_data, prot, afe;
   logic [4:0] wr_addr, rd_addr, check_en;
   logic [2:0] mode, cal_ts, amb_ts;
   logic cmd_mode, meas_run, busy, refused, self_reset, boost;
   logic signed [23:0] adc_raw;
   logic [24:0] adc_code;
   logic [15:0] free_w [3];
   logic signed [23:0] corner [4] = '{-24'sd1, 24'sd255, 24'sd256, -24'sd256};
   logic [31:0] seed = 32'h8f5e_7877;
   logic [31:0] r;
   int n_mismatch = 0, compares = 0, cycles = 0, rom_cycles = 0;
   logic seen_refused = 1'b0, seen_reset = 1'b0;
   sensor_config_command_unit #(.ROM_CHECK_CYCLES(ROM_CYC)) i_sensor_config_command_unit (
      .I_CLK(clk), .I_RSTN(rstn), .i_CMD_VALID(cmd_valid),
      .i_CMD_CODE(cmd_code), .i_CMD_FROM_LIN(cmd_lin),
      .i_WR_VALID(wr_valid), .i_WR_ADDR(wr_addr), .i_WR_DATA(wr_data),
      .i_RD_ADDR(rd_addr), .i_ROM_FAIL(rom_fail), .i_CYCLE_START(cyc_start),
      .i_ADC_RAW(adc_raw), .o_RD_DATA(rd_data), .o_MODE(mode),
      .o_CMD_MODE(cmd_mode), .o_MEASURE_RUN(meas_run), .o_BUSY(busy),
      .o_CMD_REFUSED(refused), .o_SELF_RESET(self_reset),
      .o_CHECK_EN(check_en), .o_BIAS_BOOST(boost), .o_CAL_TS(cal_ts),
      .o_AMB_TS(amb_ts), .o_ADC_CODE(adc_code));
   host_master_model i_host_master_model (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_from_lin(cmd_lin), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // xorshift source of stimulus
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // saturated code for resolution 8, inverted when pol is set
   function automatic logic [24:0] exp_adc(input logic signed [23:0] raw,
                                           input logic pol);
      logic signed [25:0] v;
      v = pol ? -raw : raw;
      if (v < 0) return 25'h000_0000;
      if (v >= 256) return 25'h000_0100;
      return v[24:0];
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic results();
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // sticky pulse monitors and run-time ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (refused === 1'b1) seen_refused <= 1'b1;
      if (self_reset === 1'b1) seen_reset <= 1'b1;
      if (mode === 3'd1) rom_cycles <= rom_cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // main sequence
   initial begin
      rstn = 1'b0;
      rom_fail = 1'b0;
      cyc_start = 1'b0;
      rd_addr = 5'h00;
      adc_raw = 24'sd0;
      settle(4);
      rstn = 1'b1;
      for (int i = 0; i < 100 && meas_run !== 1'b1; i++) settle(1);
      i_host_master_model.send_cmd(`CMD_ENTER_COMMAND, 1'b1);
      settle(1);
      check({mode, cmd_mode}, {3'd3, 1'b1});
      r = rnd();
      prot = 16'h0160 | (r[15:0] & 16'h021f);
      afe = 16'h0801 | (r[31:16] & 16'h007e);
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         free_w[i] = r[15:0];
         i_host_master_model.write_word(`FREE_USER_WORD_A + 5'(i), free_w[i]);
      end
      i_host_master_model.write_word(`CFG_AFE_ADDR, afe);
      i_host_master_model.write_word(`CFG_PROT_ADDR, prot);
      rd_addr = `FREE_USER_WORD_A;
      settle(2);
      check(rd_data, free_w[0]);
      i_host_master_model.send_cmd(`CMD_RAM_TO_EEP, 1'b1);
      settle(2);
      check({seen_refused, mode}, {1'b1, 3'd3});
      i_host_master_model.send_cmd(`CMD_RAM_TO_EEP, 1'b0);
      settle(1);
      check({busy, mode}, {1'b1, 3'd5});
      settle(34);
      for (int i = 0; i < 3; i++) i_host_master_model.write_word(`FREE_USER_WORD_A + 5'(i), 16'h0000);
      i_host_master_model.send_cmd(`CMD_EEP_TO_RAM, 1'b0);
      settle(35);
      for (int i = 0; i < 3; i++) begin
         rd_addr = `FREE_USER_WORD_A + 5'(i);
         settle(2);
         check(rd_data, free_w[i]);
      end
      i_host_master_model.send_cmd(`CMD_START_CYCLE, 1'b0);
      settle(1);
      check({meas_run, cmd_mode}, 2'b10);
      cyc_start = 1'b1;
      settle(1);
      cyc_start = 1'b0;
      settle(1);
      check({check_en, boost, cal_ts, amb_ts}, {prot[4:0], prot[9], afe[3:1], afe[6:4]});
      // corner values first, then random ones around the range ends
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         adc_raw = (i < 4) ? corner[i] : 24'(signed'(r[9:0]));
         settle(1);
         check(adc_code, exp_adc(adc_raw, 1'b1));
      end
      // plain polarity: back to command mode, clear the polarity bit
      i_host_master_model.send_cmd(`CMD_ENTER_COMMAND, 1'b0);
      i_host_master_model.write_word(`CFG_AFE_ADDR, afe & 16'hfffe);
      i_host_master_model.send_cmd(`CMD_START_CYCLE, 1'b0);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         adc_raw = (i < 4) ? corner[i] : 24'(signed'(r[9:0]));
         settle(1);
         check(adc_code, exp_adc(adc_raw, 1'b0));
      end
      // reboot with rom check, self reset and a failing rom
      rom_fail = 1'b1;
      rstn = 1'b0;
      settle(2);
      seen_reset = 1'b0;
      rom_cycles = 0;
      rstn = 1'b1;
      settle(32 + ROM_CYC + 6);
      check(rom_cycles, ROM_CYC);
      check(seen_reset, 1);
      results();
   end
endmodule
`default_nettype wire
